/* File: design/synth_ctrl_defs.svh */
// Purpose: constants for the synthesizer control byte register
// Assumes: serial frames of 8 or 32 clocks, msb first
// Notes: timing counts derived from the 125 MHz system clock
`ifndef SYNTH_CTRL_DEFS_SVH
`define SYNTH_CTRL_DEFS_SVH

// ****************************************
// field positions and reset values
// ****************************************
`define CB_PIN_A 7
`define CB_PIN_B_REF 6
`define CB_PIN_C 5
`define CB_MAIN_FLOAT 4
`define CB_SECOND_FLOAT 3
`define CB_OSC_STBY 2
`define CB_MAIN_STBY 1
`define CB_SECOND_STBY 0
`define CB_RESET 8'h03
`define CB_ADDR 4'h0
`define SHORT_FRAME 6'd8
`define LONG_FRAME 6'd32
`define KICK_TIME_US 2000
`define CLK_MHZ 125
`define KICK_CYCLES (`KICK_TIME_US * `CLK_MHZ)

`endif

/* File: design/synth_ctrl_pkg.sv */
// Purpose: types for the synthesizer control byte register
// Assumes: nothing beyond the defs header
// Notes: control byte fields as a packed struct, msb first
package synth_ctrl_pkg;
    typedef struct packed {
        logic pin_a;
        logic pin_b_or_ref_select;
        logic pin_c;
        logic main_detector_float;
        logic second_detector_float;
        logic osc_standby;
        logic main_standby;
        logic second_standby;
    } control_byte_t;

    typedef struct packed {
        logic main_correction_busy;
        logic second_correction_busy;
        logic main_phase_in_window;
        logic second_phase_in_window;
    } loop_status_t;

    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_HELD,
        LOCK_LOST
    } lock_state_t;
endpackage

/* File: design/synth_control_byte_register.sv */
// Purpose: control byte register of a dual-loop synthesizer, serially loaded
// Assumes: host shifts msb first on rising serial clock, frame framed by enable high
// Notes: serial side runs on link_clk_in; the loaded byte crosses by toggle handshake
//        link logic leaves reset two link edges after release; kick-start also in crystal with mode high
//
// Behaviour
// R1 - accept a frame of exactly eight or thirty-two serial clocks
// R2 - host puts the register address in A3..A0 of a long frame
// R3 - on frame end load the new byte; nothing else changes
// R4 - pin A follows C7 only when its two selector bits are zero
// R5 - mode low: pin B floats while C1 set, else drives C6
// R6 - mode high: C6 selects crystal (0) or external reference (1)
// R7 - C5 floats pin C when 1, drives it low when 0
// R8 - C4 floats both main detector outputs, counters keep running
// R9 - a C4 change waits until any main correction pulse ends
// R10 - with C4 set, main lock holds, drops on drift, never regains
// R11 - C3 floats secondary detector, change deferred past its correction pulse
// R12 - with C3 set, secondary lock holds, drops on drift, never regains
// R13 - C2 set shuts down oscillator and reference input
// R14 - while reference is down, keep-alive runs unless multiplier disabled
// R15 - crystal mode, C2 falling starts a few-millisecond kick-start
// R16 - host writes C2 as 1 only with C1 and C0 also 1
// R17 - multiplier standby when its three control bits are all zero
// R18 - host keeps loops in standby or float while multiplier pumps up
// R19 - each converter output presents the level of its 8-bit code
// R20 - C1 puts main loop in standby: outputs float, counters stop
// R21 - C0 puts secondary loop in standby: output floats, counters stop
// R22 - the byte holds its value between writes, also in standby
`timescale 1ns/1ps
`include "synth_ctrl_defs.svh"

module synth_control_byte_register #(
    parameter int unsigned KICK_CYCLES = `KICK_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic link_clk_in,
    input wire logic serial_enable_in,
    input wire logic serial_data_in,
    input wire logic mode_pin_in,
    input wire logic [1:0] pin_a_select_in,
    input wire logic [2:0] multiplier_ctrl_in,
    input wire logic [7:0] converter_code_one_in,
    input wire logic [7:0] converter_code_two_in,
    input wire synth_ctrl_pkg::loop_status_t loop_status_in,
    output logic [7:0] control_byte_out,
    output logic pin_a_out,
    output logic pin_a_oe_out,
    output logic pin_b_out,
    output logic pin_b_oe_out,
    output logic pin_c_out,
    output logic pin_c_oe_out,
    output logic ext_ref_select_out,
    output logic main_detector_enable_out,
    output logic second_detector_enable_out,
    output logic main_counters_run_out,
    output logic second_counters_run_out,
    output logic main_lock_out,
    output logic second_lock_out,
    output logic osc_standby_out,
    output logic keep_alive_out,
    output logic kick_start_out,
    output logic multiplier_standby_out,
    output logic [7:0] converter_out_one,
    output logic [7:0] converter_out_two
);
    import synth_ctrl_pkg::*;

    // ****************************************
    // reset release on the link clock
    // ****************************************
    logic link_rst_s1;
    logic link_rst;

    // assert at once, release after two link edges so no shift flop sees a runt release
    always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_rst_s1 <= 1'b1;
            link_rst <= 1'b1;
        end else begin
            link_rst_s1 <= 1'b0;
            link_rst <= link_rst_s1;
        end
    end

    // ****************************************
    // serial shift on the link clock
    // ****************************************
    // shift register, frame length and the byte handed across
    logic [31:0] shift;
    logic [5:0] bit_count;
    logic [7:0] link_byte;
    logic link_toggle;
    logic en_d;

    // frame end seen whenever enable falls, accepted only after 8 or 32 clocks; enable sampled on link clock
    wire frame_end = en_d & ~serial_enable_in;
    wire short_ok = (bit_count == `SHORT_FRAME); // R1
    wire long_ok = (bit_count == `LONG_FRAME) && (shift[11:8] == `CB_ADDR); // R1 R2
    wire accept = frame_end & (short_ok | long_ok);

    // shift data, count bits, capture byte and flip the toggle on a good frame
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            shift <= 32'h0;
            bit_count <= 6'h0;
            en_d <= 1'b0;
            link_byte <= `CB_RESET;
            link_toggle <= 1'b0;
        end else begin
            en_d <= serial_enable_in;
            if (serial_enable_in) begin
                shift <= {shift[30:0], serial_data_in};
                if (bit_count != 6'h3f) begin
                    bit_count <= bit_count + 6'h1;
                end
            end else begin
                bit_count <= 6'h0;
            end
            if (accept) begin
                link_byte <= shift[7:0]; // R3
                link_toggle <= ~link_toggle;
            end
        end
    end

    // ****************************************
    // crossing into the system clock
    // ****************************************
    // three toggle flops: two to settle, one to find the change
    logic tog_s1, tog_s2, tog_s3;
    logic [7:0] ctrl_q;
    control_byte_t ctrl;
    assign ctrl = control_byte_t'(ctrl_q);
    // one-cycle load strobe when the settled toggle changes
    wire load_pulse = tog_s2 ^ tog_s3;

    // toggle synchroniser; the byte is stable long before the toggle settles
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            ctrl_q <= `CB_RESET;
        end else begin
            tog_s1 <= link_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            if (load_pulse) begin
                ctrl_q <= link_byte; // R3 R22
            end
        end
    end

    // ****************************************
    // synchronise pin inputs
    // ****************************************
    // pin inputs, all but the low nibble of the second converter code, packed into one word for the two flop stages
    logic [21:0] in_s1, in_s2;
    wire [21:0] raw_in = {mode_pin_in, pin_a_select_in, multiplier_ctrl_in, loop_status_in,
                          converter_code_one_in, converter_code_two_in[7:4]};
    logic [3:0] code_two_lo_s1, code_two_lo_s2;

    // two flops on every pin input
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_s1 <= 22'h0;
            in_s2 <= 22'h0;
            code_two_lo_s1 <= 4'h0;
            code_two_lo_s2 <= 4'h0;
        end else begin
            in_s1 <= raw_in;
            in_s2 <= in_s1;
            code_two_lo_s1 <= converter_code_two_in[3:0];
            code_two_lo_s2 <= code_two_lo_s1;
        end
    end

    // unpack the settled pin inputs
    wire mode_s = in_s2[21];
    wire [1:0] a_sel_s = in_s2[20:19];
    wire [2:0] mult_s = in_s2[18:16];
    loop_status_t stat_s;
    assign stat_s = loop_status_t'(in_s2[15:12]);

    // converter codes, the second split over two flop groups
    wire [7:0] code_one_s = in_s2[11:4];
    wire [7:0] code_two_s = {in_s2[3:0], code_two_lo_s2};

    // ****************************************
    // pin and reference decode
    // ****************************************
    // pin drive levels and enables from the held byte
    wire a_gpo = (a_sel_s == 2'b00);
    wire next_pin_a_oe = a_gpo; // R4
    wire next_pin_a = a_gpo & ctrl.pin_a; // R4
    wire next_pin_b_oe = ~mode_s & ~ctrl.main_standby; // R5
    wire next_pin_b = next_pin_b_oe & ctrl.pin_b_or_ref_select; // R5
    wire next_ext_ref = mode_s & ctrl.pin_b_or_ref_select; // R6
    wire crystal_mode = ~next_ext_ref; // R6 R15
    wire next_pin_c_oe = ~ctrl.pin_c; // R7

    // reference standby side effects
    wire next_mult_stby = (mult_s == 3'b000); // R17
    wire next_keep_alive = ctrl.osc_standby & ~next_mult_stby; // R14

    // ****************************************
    // detector float deferral
    // ****************************************
    logic main_float_eff, second_float_eff;

    // requested float passes only while no correction pulse runs, else the applied state holds
    function automatic logic defer_float(input logic busy, input logic applied, input logic wanted);
        defer_float = busy ? applied : wanted;
    endfunction
    logic next_main_float, next_second_float;
    assign next_main_float = defer_float(stat_s.main_correction_busy, main_float_eff,
                                         ctrl.main_detector_float); // R8 R9
    assign next_second_float = defer_float(stat_s.second_correction_busy, second_float_eff,
                                           ctrl.second_detector_float); // R11

    // float takes effect only between correction pulses
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            main_float_eff <= 1'b0;
            second_float_eff <= 1'b0;
        end else begin
            main_float_eff <= next_main_float; // R9
            second_float_eff <= next_second_float; // R11
        end
    end

    // a detector drives only when neither floated nor in standby
    wire next_main_en = ~main_float_eff & ~ctrl.main_standby; // R8 R20
    wire next_second_en = ~second_float_eff & ~ctrl.second_standby; // R11 R21

    // ****************************************
    // lock indication while floating
    // ****************************************
    // floating: lock may only fall; otherwise it follows the window
    function automatic logic lock_next(input logic floating, input logic locked, input logic in_win);
        lock_next = floating ? (locked & in_win) : in_win;
    endfunction

    // next lock indication of each loop
    logic next_main_lock, next_second_lock;
    assign next_main_lock = lock_next(ctrl.main_detector_float, main_lock_out,
                                      stat_s.main_phase_in_window); // R10
    assign next_second_lock = lock_next(ctrl.second_detector_float, second_lock_out,
                                        stat_s.second_phase_in_window); // R12

    // ****************************************
    // kick-start timer
    // ****************************************
    // kick timer state
    logic osc_prev;
    logic [31:0] kick_count;
    // oscillator wakes when the held standby bit falls; only a crystal needs the kick
    wire kick_fire = osc_prev & ~ctrl.osc_standby & crystal_mode; // R15
    wire [31:0] next_kick = kick_fire ? KICK_CYCLES[31:0] :
                            (kick_count != 32'h0) ? kick_count - 32'h1 : 32'h0;

    // count down a few milliseconds after the oscillator wakes in crystal mode
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_prev <= 1'b0;
            kick_count <= 32'h0;
        end else begin
            osc_prev <= ctrl.osc_standby;
            kick_count <= next_kick; // R15
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    // held byte and converter levels
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            control_byte_out <= `CB_RESET;
            converter_out_one <= 8'h00;
            converter_out_two <= 8'h00;
        end else begin
            control_byte_out <= ctrl_q; // R22
            converter_out_one <= code_one_s; // R19
            converter_out_two <= code_two_s; // R19
        end
    end

    // general-purpose pins and their drive enables
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_a_out <= 1'b0;
            pin_a_oe_out <= 1'b0;
            pin_b_out <= 1'b0;
            pin_b_oe_out <= 1'b0;
            pin_c_out <= 1'b0;
            pin_c_oe_out <= 1'b0;
        end else begin
            pin_a_out <= next_pin_a; // R4
            pin_a_oe_out <= next_pin_a_oe; // R4
            pin_b_out <= next_pin_b; // R5
            pin_b_oe_out <= next_pin_b_oe; // R5
            pin_c_out <= 1'b0; // R7
            pin_c_oe_out <= next_pin_c_oe; // R7
        end
    end

    // detector enables, counters and lock indication of both loops
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            main_detector_enable_out <= 1'b0;
            second_detector_enable_out <= 1'b0;
            main_counters_run_out <= 1'b0;
            second_counters_run_out <= 1'b0;
            main_lock_out <= 1'b0;
            second_lock_out <= 1'b0;
        end else begin
            main_detector_enable_out <= next_main_en; // R8 R20
            second_detector_enable_out <= next_second_en; // R11 R21
            main_counters_run_out <= ~ctrl.main_standby; // R20
            second_counters_run_out <= ~ctrl.second_standby; // R21
            main_lock_out <= next_main_lock; // R10
            second_lock_out <= next_second_lock; // R12
        end
    end

    // reference oscillator, keep-alive, kick-start and multiplier
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            osc_standby_out <= 1'b0;
            ext_ref_select_out <= 1'b0;
            keep_alive_out <= 1'b0;
            kick_start_out <= 1'b0;
            multiplier_standby_out <= 1'b1;
        end else begin
            osc_standby_out <= ctrl.osc_standby; // R13
            ext_ref_select_out <= next_ext_ref; // R6
            keep_alive_out <= next_keep_alive; // R14
            kick_start_out <= (next_kick != 32'h0); // R15
            multiplier_standby_out <= next_mult_stby; // R17
        end
    end
endmodule

/* File: tb/serial_host_model.sv */
// Purpose: host side of the three-wire serial port
// Assumes: msb first, bits change on the falling link edge
// Notes: link clock stands still between frames, 12 ns period
`timescale 1ns/1ps
module serial_host_model (
    output logic link_clk_out,
    output logic enable_out,
    output logic data_out
);
    initial {link_clk_out, enable_out, data_out} = 3'b000;
    // one link period, rising edge in the middle
    task automatic tick();
        #6 link_clk_out = 1'b1;
        #6 link_clk_out = 1'b0;
    endtask
    // frame of n clocks, then enable low seen on three edges
    task automatic send(input int n, input logic [31:0] d);
        enable_out = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            data_out = d[i];
            tick();
        end
        enable_out = 1'b0;
        data_out = !data_out; // no stale bit once released
        repeat (3) tick();
    endtask
endmodule

/* File: tb/synth_ctrl_monitor.sv */
// Purpose: port checks for the control byte register
// Assumes: inputs steady four cycles before outputs are judged
// Notes: bound to the design below
`timescale 1ns/1ps
module synth_ctrl_monitor import synth_ctrl_pkg::*; #(
    parameter int unsigned KICK_CYCLES = 20
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic mode_pin_in,
    input wire logic [2:0] multiplier_ctrl_in,
    input wire loop_status_t loop_status_in,
    input wire logic [7:0] control_byte_out,
    input wire logic pin_b_oe_out,
    input wire logic pin_c_oe_out,
    input wire logic ext_ref_select_out,
    input wire logic main_detector_enable_out,
    input wire logic main_lock_out,
    input wire logic osc_standby_out,
    input wire logic keep_alive_out,
    input wire logic kick_start_out,
    input wire logic multiplier_standby_out
);
    logic up;
    wire [7:0] cb = control_byte_out;
    wire busy = loop_status_in.main_correction_busy;
    wire dis = !main_detector_enable_out;
    // outputs still show reset values on the first edge after release
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in || !up);
    sequence s_lo; !mode_pin_in [*4]; endsequence
    sequence s_hi; mode_pin_in [*4]; endsequence
    // decoded outputs against the held byte
    property p_pin_b; s_lo ##0 cb[1] |-> !pin_b_oe_out; endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b driven");
    property p_ext_ref; s_hi |-> ext_ref_select_out == cb[6]; endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("ref select");
    property p_pin_c; pin_c_oe_out == !cb[5]; endproperty
    a_pin_c: assert property (p_pin_c) else $error("pin c");
    property p_float; (cb[4] && !busy) [*6] |-> dis; endproperty
    a_float: assert property (p_float) else $error("float");
    property p_lock; dis && cb[4] && !main_lock_out ##1 dis && cb[4] |-> !main_lock_out; endproperty
    a_lock: assert property (p_lock) else $error("lock regained");
    property p_keep; $stable({osc_standby_out, multiplier_standby_out})
        |-> keep_alive_out == (osc_standby_out && !multiplier_standby_out); endproperty
    a_keep: assert property (p_keep) else $error("keep alive");
    property p_kick; s_lo ##0 $fell(osc_standby_out) |-> ##[0:1] kick_start_out [*8]; endproperty
    a_kick: assert property (p_kick) else $error("kick");
    property p_mult; (multiplier_ctrl_in == 3'h0) [*4] |-> multiplier_standby_out; endproperty
    a_mult: assert property (p_mult) else $error("multiplier");
    // main scenarios reached
    c_kick: cover property (kick_start_out);
    c_float: cover property (cb[4] && dis);
    c_ext: cover property (ext_ref_select_out);
endmodule
bind synth_control_byte_register synth_ctrl_monitor #(.KICK_CYCLES(KICK_CYCLES)) mon_u (
    .ref_clk_in, .sys_rst_in, .mode_pin_in, .multiplier_ctrl_in, .loop_status_in, .control_byte_out,
    .pin_b_oe_out, .pin_c_oe_out, .ext_ref_select_out, .main_detector_enable_out, .main_lock_out,
    .osc_standby_out, .keep_alive_out, .kick_start_out, .multiplier_standby_out
);

/* File: tb/synth_control_byte_register_tb.sv */
// Purpose: self-checking bench for the control byte register
// Assumes: host model drives the link, all else driven here
// Notes: kick-start cut to twenty cycles
`timescale 1ns/1ps
`include "synth_ctrl_defs.svh"
module synth_control_byte_register_tb;
    import synth_ctrl_pkg::*;
    localparam int KICK = 20;
    logic ref_clk_in, sys_rst_in, link_clk_in, serial_enable_in, serial_data_in, mode_pin_in;
    logic pin_a_out, pin_b_out, pin_b_oe_out, pin_c_oe_out, ext_ref_select_out, main_lock_out;
    logic main_detector_enable_out, second_detector_enable_out, second_lock_out;
    logic keep_alive_out, kick_start_out, multiplier_standby_out;
    logic pin_a_oe_out, pin_c_out, main_counters_run_out, second_counters_run_out, osc_standby_out;
    logic [1:0] pin_a_select_in;
    logic [2:0] multiplier_ctrl_in;
    logic [7:0] converter_code_one_in, converter_code_two_in, converter_out_one, converter_out_two;
    logic [7:0] control_byte_out, b;
    logic [31:0] v;
    loop_status_t loop_status_in;
    int err_total = 0, compares = 0, cyc = 0, seed = 32'hffaf43bf, lens[4] = '{7, 9, 31, 32};
    serial_host_model host_u (.link_clk_out(link_clk_in), .enable_out(serial_enable_in), .data_out(serial_data_in));
    synth_control_byte_register #(.KICK_CYCLES(KICK)) dut_u (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wr(input int n, input logic [31:0] d);
        host_u.send(n, d);
        w(10);
    endtask
    // standby of the oscillator only together with both loops
    function automatic logic [7:0] legal(input logic [7:0] d);
        return d[2] ? d | 8'h03 : d;
    endfunction
    // expected drive enables of pins b and c, mode low
    function automatic logic [7:0] pins(input logic [7:0] d);
        return {6'h0, !d[1], !d[5]};
    endfunction
    task automatic final_report();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = !ref_clk_in;
    end
    // cut a hung run short
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        {sys_rst_in, mode_pin_in, pin_a_select_in, multiplier_ctrl_in} = 7'h41;
        {converter_code_one_in, converter_code_two_in, loop_status_in} = 20'h0;
        host_u.tick();
        host_u.tick();
        repeat (16) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        host_u.tick();
        host_u.tick();
        w(4);
        chk(control_byte_out, `CB_RESET);
        chk(8'(pin_b_oe_out), 8'h00);
        $display("reset test done");
        // random bytes, short and addressed long frames alternating
        for (int i = 0; i < 16; i++) begin
            b = legal(8'($random(seed)));
            v = $random(seed);
            v[11:0] = {`CB_ADDR, b};
            {pin_a_select_in, converter_code_one_in, converter_code_two_in} = 18'($random(seed));
            wr(i[0] ? 32 : 8, v);
            chk(control_byte_out, b);
            chk({6'h0, pin_b_oe_out, pin_c_oe_out}, pins(b));
            if (!b[1]) chk(8'(pin_b_out), 8'(b[6]));
            if (pin_a_select_in == 2'h0) chk(8'(pin_a_out), 8'(b[7]));
            chk({7'h0, pin_a_oe_out}, {7'h0, pin_a_select_in == 2'h0});
            chk({4'h0, pin_c_out, osc_standby_out, main_counters_run_out, second_counters_run_out},
                {5'h0, b[2], !b[1], !b[0]});
            chk(converter_out_one, converter_code_one_in);
            chk(converter_out_two, converter_code_two_in);
        end
        $display("random frame test done");
        // bad lengths and a wrong address leave the byte alone
        foreach (lens[k]) begin
            wr(lens[k], 32'hffff_f55a);
            chk(control_byte_out, b);
        end
        $display("refusal test done");
        mode_pin_in = 1'b1;
        for (int k = 0; k < 2; k++) begin
            b = k[0] ? 8'h43 : 8'h03;
            wr(8, b | 8'h04);
            // wake the oscillator: a crystal kicks, an external reference does not
            host_u.send(8, b);
            w(8);
            chk(8'(kick_start_out), 8'(!b[6]));
            w(KICK);
            chk(8'(ext_ref_select_out), 8'(b[6]));
        end
        mode_pin_in = 1'b0;
        wr(8, 8'h07);
        chk(8'(keep_alive_out), 8'h01);
        host_u.send(8, 8'h03);
        w(8);
        chk(8'(kick_start_out), 8'h01);
        w(KICK + 10);
        chk(8'(kick_start_out), 8'h00);
        multiplier_ctrl_in = 3'h0;
        wr(8, 8'h07);
        chk({6'h0, multiplier_standby_out, keep_alive_out}, 8'h02);
        multiplier_ctrl_in = 3'h1;
        w(20);
        $display("oscillator test done");
        // float set while correction pulses run, then applied once they end
        loop_status_in = 4'hf;
        wr(8, 8'h00);
        wr(8, 8'h18);
        chk({6'h0, main_detector_enable_out, second_detector_enable_out}, 8'h03);
        loop_status_in = 4'h3;
        w(8);
        chk({6'h0, main_detector_enable_out, second_detector_enable_out}, 8'h00);
        chk({6'h0, main_lock_out, second_lock_out}, 8'h03);
        loop_status_in = 4'h0;
        w(8);
        loop_status_in = 4'h3;
        w(8);
        chk({6'h0, main_lock_out, second_lock_out}, 8'h00);
        $display("float test done");
        final_report();
    end
endmodule
